// File: rtl/ivfr_core.sv
// Input over-voltage reaction, restart sequencing and under-voltage limit
`timescale 1ns/1ps
`default_nettype none
module ivfr_core #(
  parameter int unsigned RETRY_CYC = ivfr_pkg::RETRY_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ivfr_pkg::ivfr_req_t req,
  input wire logic ov_detect,
  input wire logic [15:0] vin_meas,
  input wire logic fault_clear,
  input wire logic on_cmd,
  input wire logic bias_ok,
  input wire logic other_fault,
  output logic [15:0] rdata_q,
  output ivfr_pkg::ivfr_status_t status_q
);
  import ivfr_pkg::*;

  logic [7:0] reaction_q;
  logic [15:0] uv_limit_q;
  ivfr_state_t st_q;
  logic [31:0] div_q;
  logic [2:0] units_q;
  logic on_ok;
  logic disable_mode;
  logic [2:0] cnt_cfg;
  logic [2:0] gap_cfg;
  logic ov_trip;
  logic give_up;
  logic attempt_go;
  logic restart_tmr;
  logic out_en_q;
  logic ov_flag_q;
  logic uv_flag_q;
  logic exp_err_q;
  logic latched_q;
  logic [2:0] attempts_q;

  // Decoded settings; unknown actions fall back to ignore
  assign cnt_cfg = reaction_q[CNT_HI:CNT_LO];
  assign gap_cfg = reaction_q[GAP_HI:GAP_LO];
  assign disable_mode = (reaction_q[ACT_HI:ACT_LO] == ACT_DISABLE);
  assign on_ok = on_cmd && bias_ok && !other_fault;
  assign ov_trip = (st_q == IVFR_RUN) && on_ok && ov_detect && disable_mode;
  // Out of retries: none allowed, or the finite budget used up
  assign give_up = (cnt_cfg == CNT_NONE) ||
                   ((cnt_cfg != CNT_ENDLESS) && (attempts_q >= cnt_cfg));
  assign attempt_go = (st_q == IVFR_WAIT) && on_ok && (units_q >= gap_cfg);
  // Timer starts at the first shutdown and at every attempt start
  assign restart_tmr = attempt_go || (ov_trip && (attempts_q == 3'h0));
  // One flop per status field, so each field has a single owning process
  assign status_q = '{out_en: out_en_q, ov_flag: ov_flag_q, uv_flag: uv_flag_q,
                      exp_err: exp_err_q, latched: latched_q, attempts: attempts_q};

  // Settings registers, written by command code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reaction_q <= REACTION_RST;
      uv_limit_q <= UV_LIMIT_RST;
    end else if (req.wr) begin
      if (req.code == OFF_REACTION) begin
        reaction_q <= req.wdata[7:0];
      end else if (req.code == OFF_UV_LIMIT) begin
        uv_limit_q <= req.wdata;
      end
    end
  end

  // Read data; unmapped codes and unused upper bits read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      case (req.code)
        OFF_REACTION: rdata_q <= {8'h00, reaction_q};
        OFF_UV_LIMIT: rdata_q <= uv_limit_q;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  // Exponent check; a bad exponent is kept but flagged for the host
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_err_q <= 1'b0;
    end else if (req.wr && (req.code == OFF_UV_LIMIT)) begin
      exp_err_q <= (req.wdata[LIN_EXP_HI:LIN_EXP_LO] != UV_EXP);
    end
  end

  // Sequencer: run, wait out the interval, or latch off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= IVFR_IDLE;
    end else if (!on_ok) begin
      st_q <= IVFR_IDLE;
    end else begin
      case (st_q)
        IVFR_IDLE: st_q <= IVFR_RUN;
        IVFR_RUN: begin
          if (ov_trip) begin
            st_q <= give_up ? IVFR_LATCH : IVFR_WAIT;
          end
        end
        IVFR_WAIT: begin
          if (attempt_go) begin
            st_q <= IVFR_RUN;
          end
        end
        IVFR_LATCH: begin
          if (fault_clear) begin
            st_q <= IVFR_IDLE;
          end
        end
        default: st_q <= IVFR_IDLE;
      endcase
    end
  end

  // Output enable follows the next state so it changes with the sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_q <= 1'b0;
      latched_q <= 1'b0;
    end else if (!on_ok) begin
      out_en_q <= 1'b0;
      latched_q <= 1'b0;
    end else begin
      case (st_q)
        IVFR_IDLE: out_en_q <= 1'b1;
        IVFR_RUN: begin
          out_en_q <= !ov_trip;
          latched_q <= ov_trip && give_up;
        end
        IVFR_WAIT: out_en_q <= attempt_go;
        IVFR_LATCH: latched_q <= !fault_clear;
        default: out_en_q <= 1'b0;
      endcase
    end
  end

  // Attempt counter; cleared on fault clear or command off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      attempts_q <= 3'h0;
    end else if (!on_ok || fault_clear) begin
      attempts_q <= 3'h0;
    end else if (attempt_go && (attempts_q != 3'h7)) begin
      attempts_q <= attempts_q + 3'h1;
    end
  end

  // Interval timer; restarted so spacing runs start to start, not end to start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 32'h0;
      units_q <= 3'h0;
    end else if (restart_tmr) begin
      div_q <= 32'h0;
      units_q <= 3'h0;
    end else if (div_q >= 32'(RETRY_CYC - 1)) begin
      div_q <= 32'h0;
      if (units_q != 3'h7) begin
        units_q <= units_q + 3'h1;
      end
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // Sticky fault flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_flag_q <= 1'b0;
      uv_flag_q <= 1'b0;
    end else begin
      if (ov_detect) begin
        ov_flag_q <= 1'b1;
      end else if (fault_clear) begin
        ov_flag_q <= 1'b0;
      end
      // Strictly below the limit; equal is not a fault
      if (vin_meas < {5'h00, uv_limit_q[LIN_MAN_HI:0]}) begin
        uv_flag_q <= 1'b1;
      end else if (fault_clear) begin
        uv_flag_q <= 1'b0;
      end
    end
  end

  // Helper: interval units counted on its own from each visible attempt start
  // It lags the real timer by one cycle, which makes the gap check exact
  logic hp_en_q;
  logic [31:0] hp_div_q;
  logic [3:0] hp_units_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hp_en_q <= 1'b0;
      hp_div_q <= 32'h0;
      hp_units_q <= 4'h0;
    end else begin
      hp_en_q <= out_en_q;
      if (out_en_q && !hp_en_q) begin
        hp_div_q <= 32'h0;
        hp_units_q <= 4'h0;
      end else if (hp_div_q == 32'(RETRY_CYC - 1)) begin
        hp_div_q <= 32'h0;
        hp_units_q <= (hp_units_q == 4'hF) ? hp_units_q : hp_units_q + 4'h1;
      end else begin
        hp_div_q <= hp_div_q + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ignore_keeps_on_a: assert property (
    (st_q == IVFR_RUN) && on_ok && ov_detect && !disable_mode |=> out_en_q)
    else $error("output dropped while fault is ignored");
  ov_shutdown_a: assert property (
    (st_q == IVFR_RUN) && on_ok && ov_detect && disable_mode |=> !out_en_q)
    else $error("output not disabled on over-voltage");
  no_retry_a: assert property (
    ov_trip && (cnt_cfg == CNT_NONE) |=> latched_q ##1 (!out_en_q || !on_ok))
    else $error("restart attempted with count zero");
  retry_limit_a: assert property (
    $rose(latched_q) |-> ($past(cnt_cfg) == CNT_NONE) ||
      ($past(attempts_q) == $past(cnt_cfg)))
    else $error("latched off before retry budget used");
  endless_retry_a: assert property (
    ov_trip && (cnt_cfg == CNT_ENDLESS) |=> (st_q == IVFR_WAIT) && !latched_q)
    else $error("endless retry gave up");
  exp_flag_a: assert property (
    req.wr && (req.code == OFF_UV_LIMIT) |=>
      exp_err_q == ($past(req.wdata[LIN_EXP_HI:LIN_EXP_LO]) != UV_EXP))
    else $error("exponent check wrong");
  uv_trip_a: assert property (
    $rose(uv_flag_q) |-> $past(vin_meas) < {5'h00, $past(uv_limit_q[LIN_MAN_HI:0])})
    else $error("under-voltage flag without crossing");
  retry_gap_a: assert property (
    out_en_q && !hp_en_q && (attempts_q > 3'h1) |-> (hp_units_q >= {1'b0, gap_cfg}))
    else $error("restart before interval elapsed");
  off_clears_a: assert property (
    !on_ok |=> (attempts_q == 3'h0) && !out_en_q)
    else $error("attempt count kept after command off");

  shutdown_c: cover property (ov_trip ##1 (st_q == IVFR_WAIT));
  restart_c: cover property ((st_q == IVFR_WAIT) ##1 (st_q == IVFR_RUN));
  latch_c: cover property ($rose(latched_q));
  clear_c: cover property ((st_q == IVFR_LATCH) && fault_clear);
endmodule // ivfr_core
`default_nettype wire

// File: rtl/ivfr_pkg.sv
// Package for the input voltage fault retry block: map, fields, timing, carriers
package ivfr_pkg;
  // Command codes of the two settings
  localparam logic [7:0] OFF_REACTION = 8'h56;
  localparam logic [7:0] OFF_UV_LIMIT = 8'h59;
  // Reset values
  localparam logic [7:0] REACTION_RST = 8'h00;
  localparam logic [15:0] UV_LIMIT_RST = 16'h0000;
  // Reaction byte fields
  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int CNT_HI = 5;
  localparam int CNT_LO = 3;
  localparam int GAP_HI = 2;
  localparam int GAP_LO = 0;
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_DISABLE = 2'h2;
  localparam logic [2:0] CNT_NONE = 3'h0;
  localparam logic [2:0] CNT_ENDLESS = 3'h7;
  // Linear format layout, exponent minus three
  localparam int LIN_EXP_HI = 15;
  localparam int LIN_EXP_LO = 11;
  localparam int LIN_MAN_HI = 10;
  localparam logic [4:0] UV_EXP = 5'h1D;
  // Retry interval unit
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned RETRY_UNIT_MS = 200;
  localparam int unsigned RETRY_UNIT_CYC = RETRY_UNIT_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    IVFR_IDLE,
    IVFR_RUN,
    IVFR_WAIT,
    IVFR_LATCH
  } ivfr_state_t;

  // Register access request from the command decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } ivfr_req_t;

  // Status seen by the rest of the power stage
  typedef struct packed {
    logic out_en;
    logic ov_flag;
    logic uv_flag;
    logic exp_err;
    logic latched;
    logic [2:0] attempts;
  } ivfr_status_t;
endpackage

// File: verification/ivfr_host.sv
// Host controller model driving the register command port of the core
`timescale 1ns/1ps
`default_nettype none
module ivfr_host (
  input wire logic clk,
  input wire logic [15:0] rdata_q,
  output var ivfr_pkg::ivfr_req_t req
);
  import ivfr_pkg::*;
  initial req = '0;
  // One strobe per call; released fields are scrambled, not left stale
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q);
    @(negedge clk);
    req <= '{wr: w, rd: !w, code: c, wdata: d};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: ~d};
    @(negedge clk);
    q = rdata_q;
  endtask
  // Limit always sent with exponent minus three
  task automatic put_lim(input logic [10:0] m);
    logic [15:0] q;
    xfer(1'b1, OFF_UV_LIMIT, {UV_EXP, m}, q);
  endtask
endmodule // ivfr_host
`default_nettype wire

// File: verification/tb_ivfr_core.sv
// Self-checking bench for the input voltage fault retry core
`timescale 1ns/1ps
`default_nettype none
module tb_ivfr_core;
  import ivfr_pkg::*;
  localparam int unsigned RC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ov_detect = 1'b0;
  logic [15:0] vin_meas = 16'hFFFF;
  logic fault_clear = 1'b0;
  logic on_cmd = 1'b1;
  logic bias_ok = 1'b1;
  logic other_fault = 1'b0;
  logic [15:0] rdata_q;
  ivfr_req_t req;
  ivfr_status_t st;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] rs = 32'h289E8F4C;
  always #50 clk = ~clk;
  ivfr_core #(.RETRY_CYC(RC)) u_ivfr_core (.clk(clk), .rst_n(rst_n), .req(req),
    .ov_detect(ov_detect), .vin_meas(vin_meas), .fault_clear(fault_clear),
    .on_cmd(on_cmd), .bias_ok(bias_ok), .other_fault(other_fault),
    .rdata_q(rdata_q), .status_q(st));
  ivfr_host u_ivfr_host (.clk(clk), .rdata_q(rdata_q), .req(req));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait on the output enable, so a stuck design cannot hang us
  task automatic wait_en(input logic v, input int n);
    for (int i = 0; i < n && st.out_en !== v; i++) @(negedge clk);
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Whole run needs only several hundred cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    logic [15:0] q;
    logic [10:0] m;
    logic [2:0] g;
    int t0;
    gap(12);
    chk({8'h00, st}, 16'h0000);
    rst_n = 1'b1;
    u_ivfr_host.xfer(1'b0, OFF_REACTION, 16'h0000, q);
    chk(q, {8'h00, REACTION_RST});
    u_ivfr_host.xfer(1'b0, OFF_UV_LIMIT, 16'h0000, q);
    chk(q, UV_LIMIT_RST);
    // Random reaction byte, junk in the upper byte must not read back
    rs = xs(rs);
    u_ivfr_host.xfer(1'b1, OFF_REACTION, rs[15:0], q);
    u_ivfr_host.xfer(1'b0, OFF_REACTION, 16'h0000, q);
    chk(q, {8'h00, rs[7:0]});
    u_ivfr_host.xfer(1'b0, 8'h00, 16'h0000, q);
    chk(q, 16'h0000);
    // Trip only below the limit, equal level is no fault
    m = rs[26:16] | 11'h002;
    u_ivfr_host.put_lim(m);
    u_ivfr_host.xfer(1'b0, OFF_UV_LIMIT, 16'h0000, q);
    chk(q, {UV_EXP, m});
    vin_meas = {5'h00, m};
    gap(3);
    chk(16'({st.uv_flag, st.exp_err}), 16'h0000);
    vin_meas = {5'h00, m - 11'h001};
    gap(3);
    chk(16'(st.uv_flag), 16'h0001);
    // A limit with the wrong exponent is kept but flagged
    u_ivfr_host.xfer(1'b1, OFF_UV_LIMIT, {5'h00, m}, q);
    chk(16'(st.exp_err), 16'h0001);
    u_ivfr_host.put_lim(m);
    chk(16'(st.exp_err), 16'h0000);
    vin_meas = 16'hFFFF;
    // Ignore codes keep the output up through the fault
    foreach (g[i]) begin
      u_ivfr_host.xfer(1'b1, OFF_REACTION, {8'h00, i[1:0] + 2'(i > 1), 6'h09}, q);
      ov_detect = 1'b1;
      gap(10);
      chk(16'({st.out_en, st.ov_flag, st.attempts}), 16'h0018);
      ov_detect = 1'b0;
    end
    // Each finite count: exact number of restarts, then latched off
    for (int n = 0; n < 7; n++) begin
      rs = xs(rs);
      g = rs[2:0] % 3;
      u_ivfr_host.xfer(1'b1, OFF_REACTION, {8'h00, ACT_DISABLE, 3'(n), g}, q);
      wait_en(1'b1, 10);
      ov_detect = 1'b1;
      gap(1);
      chk(16'(st.out_en), 16'h0000);
      for (int i = 0; i < 7 * (g * RC + 3) + 10 && st.latched !== 1'b1; i++) gap(1);
      ov_detect = 1'b0;
      gap(3);
      chk(16'({st.out_en, st.latched, st.attempts}), 16'({2'b01, 3'(n)}));
      fault_clear = 1'b1;
      gap(1);
      fault_clear = 1'b0;
      gap(2);
      chk(16'({st.latched, st.ov_flag, st.uv_flag, st.attempts}), 16'h0000);
      wait_en(1'b1, 10);
    end
    // Endless retries: start-to-start spacing of one interval unit
    u_ivfr_host.xfer(1'b1, OFF_REACTION, 16'h00B9, q);
    ov_detect = 1'b1;
    wait_en(1'b0, 5);
    wait_en(1'b1, 20);
    t0 = cyc;
    wait_en(1'b0, 5);
    wait_en(1'b1, 20);
    chk(16'(cyc - t0 >= RC && cyc - t0 <= RC + 1), 16'h0001);
    // Off command, bias loss, other fault each end the retries
    for (int k = 0; k < 3; k++) begin
      gap(60);
      chk(16'({st.latched, st.attempts}), 16'h0007);
      {on_cmd, bias_ok, other_fault} = 3'b110 ^ (3'b100 >> k);
      gap(3);
      chk(16'({st.out_en, st.attempts}), 16'h0000);
      {on_cmd, bias_ok, other_fault} = 3'b110;
    end
    close_out();
  end
endmodule // tb_ivfr_core
`default_nettype wire
